//--- hdl/vom_mixer.sv
// Overlay mixer: logo, text line or circle keyed onto the test picture
`timescale 1ns/1ps

module vom_mixer #(
   parameter int ACT_W = 1920,
   parameter int ACT_H = 1080,
   parameter int FAST_TOGGLE = vom_pkg::FAST_TOGGLE_CYC,
   parameter int SLOW_TOGGLE = vom_pkg::SLOW_TOGGLE_CYC
) (
   input wire logic clk,
   input wire logic rstn,
   input wire logic [vom_pkg::ADDR_W-1:0] regAddr,
   input wire logic [vom_pkg::DATA_W-1:0] regWdata,
   input wire logic regWrite,
   input wire logic regRead,
   output logic [vom_pkg::DATA_W-1:0] regRdata,
   input wire logic inValid,
   output logic inReady,
   input wire vom_pkg::vom_pix_t inPix,
   output logic outValid,
   input wire logic outReady,
   output vom_pkg::vom_pix_t outPix
);

   typedef struct packed {
      vom_pkg::vom_cfg_t cfg;
      vom_pkg::vom_cfg_t act;
      vom_pkg::vom_geom_t geom;
      logic [vom_pkg::TEXT_LEN-1:0][7:0] text;
      logic [vom_pkg::TEXT_LEN-1:0][7:0] textAct;
      logic [vom_pkg::LOGO_N-1:0][vom_pkg::LOGO_N-1:0] logo;
      logic [vom_pkg::LOGO_N-1:0][vom_pkg::LOGO_N-1:0] logoAct;
      logic [vom_pkg::DATA_W-1:0] rdata;
      logic [11:0] x;
      logic [11:0] y;
      logic started;
      logic [31:0] blinkCnt;
      logic blinkVis;
      logic visAct;
   } vom_st_t;

   vom_st_t st_r;
   vom_st_t st_nxt;

   logic accept;
   logic frameEnd;
   logic latch;
   logic [11:0] curX;
   logic [11:0] curY;
   logic signed [13:0] lRx;
   logic signed [13:0] lRy;
   logic signed [13:0] tRx;
   logic signed [13:0] tRy;
   logic signed [13:0] cDx;
   logic signed [13:0] cDy;
   logic signed [13:0] rIn;
   logic signed [27:0] dx2;
   logic signed [27:0] dy2;
   logic signed [27:0] rOut2;
   logic signed [27:0] rIn2;
   logic [28:0] dist2;
   logic [4:0] charIdx;
   logic [7:0] curChar;
   logic [3:0] cellCol;
   logic logoHit;
   logic textHit;
   logic circHit;
   logic overlayOn;
   vom_pkg::vom_pix_t mixPix;

   // Saturate a written field into its legal range
   function automatic int clampInt(input int v, input int lo, input int hi);
      if (v < lo) begin
         return lo;
      end else if (v > hi) begin
         return hi;
      end
      return v;
   endfunction : clampInt

   // Position in steps of 1/den of a full dimension, as pixels
   function automatic logic signed [13:0] pctPix(input int pct,
                                                 input int full,
                                                 input int den);
      int v;
      v = pct * full / den;
      return 14'(v);
   endfunction : pctPix

   // Word index inside a register window, or -1 when outside it
   function automatic int winIdx(input logic [9:0] addr,
                                 input logic [9:0] base,
                                 input int len);
      int off;
      off = int'(addr) - int'(base);
      if (off < 0 || off[1:0] != 2'b00 || (off >> 2) >= len) begin
         return -1;
      end
      return off >> 2;
   endfunction : winIdx

   // Pixel coordinates of the beat on the input; start of frame is origin
   assign accept = inValid & inReady;
   assign curX = inPix.sof ? 12'h000 : st_r.x;
   assign curY = inPix.sof ? 12'h000 : st_r.y;
   // Last line's end closes the frame; before the first frame we follow live
   assign frameEnd = accept & inPix.eol & (curY == 12'(ACT_H - 1));
   assign latch = frameEnd | !st_r.started;

   // Logo window hit, one bitmap bit per pixel
   assign lRx = $signed({2'b00, curX}) - st_r.geom.logoX0;
   assign lRy = $signed({2'b00, curY}) - st_r.geom.logoY0;
   always_comb begin
      logoHit = 1'b0;
      if (lRx >= 0 && lRx < vom_pkg::LOGO_N &&
          lRy >= 0 && lRy < vom_pkg::LOGO_N) begin
         logoHit = st_r.logoAct[lRy[vom_pkg::LOGO_SH-1:0]]
                               [lRx[vom_pkg::LOGO_SH-1:0]];
      end
   end

   // Text line hit; each character other than blank or NUL is a solid block glyph in its cell
   assign tRx = $signed({2'b00, curX}) - st_r.geom.textX0;
   assign tRy = $signed({2'b00, curY}) - st_r.geom.textY0;
   assign charIdx = tRx[vom_pkg::CELL_SH +: 5];
   assign cellCol = tRx[vom_pkg::CELL_SH-1:0];
   assign curChar = (charIdx < 5'(vom_pkg::TEXT_LEN)) ?
                    st_r.textAct[charIdx] : vom_pkg::CHAR_BLANK;
   always_comb begin
      textHit = 1'b0;
      if (tRx >= 0 &&
          tRx < (vom_pkg::TEXT_LEN << vom_pkg::CELL_SH) &&
          tRy >= 0 && tRy < vom_pkg::CELL_H) begin
         textHit = (curChar != vom_pkg::CHAR_BLANK) &&
                   (curChar != vom_pkg::CHAR_NUL) &&
                   (cellCol >= 4'(vom_pkg::GLYPH_X0)) &&
                   (cellCol <= 4'(vom_pkg::GLYPH_X1)) &&
                   (tRy >= vom_pkg::GLYPH_Y0) &&
                   (tRy <= vom_pkg::GLYPH_Y1);
      end
   end

   // Circle outline: one pixel ring between radius-1 and radius
   assign cDx = $signed({2'b00, curX}) - st_r.geom.circCx;
   assign cDy = $signed({2'b00, curY}) - st_r.geom.circCy;
   assign rIn = st_r.geom.circR - 14'sd1;
   assign dx2 = cDx * cDx;
   assign dy2 = cDy * cDy;
   assign rOut2 = st_r.geom.circR * st_r.geom.circR;
   assign rIn2 = rIn * rIn;
   assign dist2 = 29'(dx2) + 29'(dy2);
   assign circHit = (st_r.geom.circR > 0) &&
                    (dist2 <= 29'(rOut2)) && (dist2 > 29'(rIn2));

   // Only the selected object is keyed, and only while it is enabled
   always_comb begin
      overlayOn = 1'b0;
      unique case (st_r.act.obj)
         vom_pkg::OBJ_LOGO: begin
            overlayOn = (st_r.act.logoSel != 4'h0) & logoHit;
         end
         vom_pkg::OBJ_TEXT: begin
            overlayOn = st_r.act.textEn & textHit;
         end
         vom_pkg::OBJ_CIRCLE: begin
            overlayOn = st_r.act.circEn & circHit;
         end
         default: begin
            overlayOn = 1'b0;
         end
      endcase
   end

   // Blink gates the keyed pixel; with no hit the picture passes as is
   always_comb begin
      mixPix = inPix;
      if (overlayOn && st_r.visAct) begin
         mixPix.data = vom_pkg::OVL_PIX;
      end
   end

   // Register port, pixel counters, blink timer and frame-boundary copy
   always_comb begin
      int ti;
      int li;
      ti = winIdx(regAddr, vom_pkg::REG_TEXT_BASE, vom_pkg::TEXT_LEN);
      li = winIdx(regAddr, vom_pkg::REG_LOGO_BASE, vom_pkg::LOGO_N);
      st_nxt = st_r;
      st_nxt.rdata = '0;

      // Writes land in the live copy only; the picture never sees them yet
      if (regWrite) begin
         if (regAddr == vom_pkg::REG_CTRL) begin
            st_nxt.cfg.logoSel = regWdata[vom_pkg::CTRL_LOGO_LSB +: 4];
            st_nxt.cfg.textEn = regWdata[vom_pkg::CTRL_TEXT_EN];
            st_nxt.cfg.circEn = regWdata[vom_pkg::CTRL_CIRC_EN];
            // Code 3 names no object or mode, so it leaves the field alone
            if (regWdata[vom_pkg::CTRL_OBJ_LSB +: 2] != 2'h3) begin
               st_nxt.cfg.obj = vom_pkg::vom_obj_t'(
                  regWdata[vom_pkg::CTRL_OBJ_LSB +: 2]);
            end
            if (regWdata[vom_pkg::CTRL_BLINK_LSB +: 2] != 2'h3) begin
               st_nxt.cfg.blink = vom_pkg::vom_blink_t'(
                  regWdata[vom_pkg::CTRL_BLINK_LSB +: 2]);
            end
         end else if (regAddr == vom_pkg::REG_LOGO_POS) begin
            st_nxt.cfg.logoX = 11'(clampInt(
               int'($signed(regWdata[vom_pkg::POS_X_LSB +: 11])),
               vom_pkg::LOGO_MIN, vom_pkg::LOGO_MAX));
            st_nxt.cfg.logoY = 11'(clampInt(
               int'($signed(regWdata[vom_pkg::POS_Y_LSB +: 11])),
               vom_pkg::LOGO_MIN, vom_pkg::LOGO_MAX));
         end else if (regAddr == vom_pkg::REG_TEXT_POS) begin
            st_nxt.cfg.textX = 7'(clampInt(
               int'(regWdata[vom_pkg::POS_X_LSB +: 7]),
               vom_pkg::TEXT_MIN, vom_pkg::TEXT_MAX));
            st_nxt.cfg.textY = 7'(clampInt(
               int'(regWdata[vom_pkg::POS_Y_LSB +: 7]),
               vom_pkg::TEXT_MIN, vom_pkg::TEXT_MAX));
         end else if (regAddr == vom_pkg::REG_CIRC) begin
            st_nxt.cfg.circX = 7'(clampInt(
               int'($signed(regWdata[vom_pkg::POS_X_LSB +: 7])),
               vom_pkg::CIRC_MIN, vom_pkg::CIRC_MAX));
            st_nxt.cfg.circY = 7'(clampInt(
               int'($signed(regWdata[vom_pkg::POS_Y_LSB +: 7])),
               vom_pkg::CIRC_MIN, vom_pkg::CIRC_MAX));
            st_nxt.cfg.circD = 7'(clampInt(
               int'(regWdata[vom_pkg::CIRC_D_LSB +: 7]),
               0, vom_pkg::DIAM_MAX));
         end else if (ti >= 0) begin
            st_nxt.text[ti] = regWdata[7:0];
         end else if (li >= 0) begin
            st_nxt.logo[li] = regWdata[vom_pkg::LOGO_N-1:0];
         end
      end

      // Reads answer in the next cycle; unmapped words read as zero
      if (regRead) begin
         if (regAddr == vom_pkg::REG_CTRL) begin
            st_nxt.rdata[vom_pkg::CTRL_LOGO_LSB +: 4] = st_r.cfg.logoSel;
            st_nxt.rdata[vom_pkg::CTRL_TEXT_EN] = st_r.cfg.textEn;
            st_nxt.rdata[vom_pkg::CTRL_CIRC_EN] = st_r.cfg.circEn;
            st_nxt.rdata[vom_pkg::CTRL_OBJ_LSB +: 2] = st_r.cfg.obj;
            st_nxt.rdata[vom_pkg::CTRL_BLINK_LSB +: 2] = st_r.cfg.blink;
         end else if (regAddr == vom_pkg::REG_LOGO_POS) begin
            st_nxt.rdata[vom_pkg::POS_X_LSB +: 11] = st_r.cfg.logoX;
            st_nxt.rdata[vom_pkg::POS_Y_LSB +: 11] = st_r.cfg.logoY;
         end else if (regAddr == vom_pkg::REG_TEXT_POS) begin
            st_nxt.rdata[vom_pkg::POS_X_LSB +: 7] = st_r.cfg.textX;
            st_nxt.rdata[vom_pkg::POS_Y_LSB +: 7] = st_r.cfg.textY;
         end else if (regAddr == vom_pkg::REG_CIRC) begin
            st_nxt.rdata[vom_pkg::POS_X_LSB +: 7] = st_r.cfg.circX;
            st_nxt.rdata[vom_pkg::POS_Y_LSB +: 7] = st_r.cfg.circY;
            st_nxt.rdata[vom_pkg::CIRC_D_LSB +: 7] = st_r.cfg.circD;
         end else if (regAddr == vom_pkg::REG_STATUS) begin
            st_nxt.rdata[vom_pkg::STAT_BLINK] = st_r.blinkVis;
            st_nxt.rdata[vom_pkg::STAT_VIS] = st_r.visAct;
            st_nxt.rdata[vom_pkg::STAT_RUN] = st_r.started;
            st_nxt.rdata[vom_pkg::STAT_LINE_LSB +: 12] = st_r.y;
         end else if (ti >= 0) begin
            st_nxt.rdata[7:0] = st_r.text[ti];
         end else if (li >= 0) begin
            st_nxt.rdata[vom_pkg::LOGO_N-1:0] = st_r.logo[li];
         end
      end

      // Pixel position advances only on beats that really move
      if (accept) begin
         if (inPix.sof) begin
            st_nxt.started = 1'b1;
         end
         if (inPix.eol) begin
            st_nxt.x = 12'h000;
            st_nxt.y = curY + 12'h001;
         end else begin
            st_nxt.x = curX + 12'h001;
            st_nxt.y = curY;
         end
      end

      // Free-running blink timer; half a period per visibility toggle
      if (st_r.cfg.blink == vom_pkg::BLINK_OFF) begin
         st_nxt.blinkCnt = '0;
         st_nxt.blinkVis = 1'b1;
      end else if (st_r.blinkCnt >= 32'((st_r.cfg.blink ==
                   vom_pkg::BLINK_FAST ? FAST_TOGGLE : SLOW_TOGGLE) - 1)) begin
         st_nxt.blinkCnt = '0;
         st_nxt.blinkVis = !st_r.blinkVis;
      end else begin
         st_nxt.blinkCnt = st_r.blinkCnt + 32'h0000_0001;
      end

      // Frame boundary: copy settings and rescale them to pixels at once,
      // so the dividers sit once per frame and not in the pixel path
      if (latch) begin
         st_nxt.act = st_r.cfg;
         st_nxt.textAct = st_r.text;
         st_nxt.logoAct = st_r.logo;
         st_nxt.visAct = st_r.blinkVis;
         st_nxt.geom.logoX0 = pctPix(-int'(st_r.cfg.logoX), ACT_W,
                                     vom_pkg::LOGO_DEN);
         st_nxt.geom.logoY0 = pctPix(-int'(st_r.cfg.logoY), ACT_H,
                                     vom_pkg::LOGO_DEN);
         st_nxt.geom.textX0 = pctPix(int'(st_r.cfg.textX), ACT_W,
                                     vom_pkg::PCT_DEN);
         st_nxt.geom.textY0 = pctPix(int'(st_r.cfg.textY), ACT_H,
                                     vom_pkg::PCT_DEN);
         st_nxt.geom.circCx = 14'(ACT_W / 2) + pctPix(int'(st_r.cfg.circX),
                              ACT_W, vom_pkg::PCT_DEN);
         st_nxt.geom.circCy = 14'(ACT_H / 2) + pctPix(int'(st_r.cfg.circY),
                              ACT_H, vom_pkg::PCT_DEN);
         st_nxt.geom.circR = pctPix(int'(st_r.cfg.circD), ACT_H,
                                    2 * vom_pkg::PCT_DEN);
      end
   end

   always_ff @(posedge clk or negedge rstn) begin
      if (!rstn) begin
         st_r <= '0;
      end else begin
         st_r <= st_nxt;
      end
   end

   assign regRdata = st_r.rdata;

   // A stalled output holds two words, so no pixel is dropped on back-pressure
   vom_skid #(
      .W($bits(vom_pkg::vom_pix_t))
   ) u_skid (
      .clk(clk),
      .rstn(rstn),
      .inValid(inValid),
      .inReady(inReady),
      .inData(mixPix),
      .outValid(outValid),
      .outReady(outReady),
      .outData(outPix)
   );

endmodule : vom_mixer

//--- hdl/vom_pkg.sv
// Shared constants, register map and types of the video overlay mixer
package vom_pkg;

   // Register port geometry
   localparam int ADDR_W = 10;
   localparam int DATA_W = 32;

   // Register byte offsets
   localparam logic [9:0] REG_CTRL = 10'h000;
   localparam logic [9:0] REG_LOGO_POS = 10'h004;
   localparam logic [9:0] REG_TEXT_POS = 10'h008;
   localparam logic [9:0] REG_CIRC = 10'h00C;
   localparam logic [9:0] REG_STATUS = 10'h010;
   localparam logic [9:0] REG_TEXT_BASE = 10'h040;
   localparam logic [9:0] REG_LOGO_BASE = 10'h100;

   // Field positions
   localparam int CTRL_LOGO_LSB = 0;
   localparam int CTRL_TEXT_EN = 4;
   localparam int CTRL_CIRC_EN = 5;
   localparam int CTRL_OBJ_LSB = 8;
   localparam int CTRL_BLINK_LSB = 12;
   localparam int POS_X_LSB = 0;
   localparam int POS_Y_LSB = 16;
   localparam int CIRC_D_LSB = 24;
   localparam int STAT_BLINK = 0;
   localparam int STAT_VIS = 1;
   localparam int STAT_RUN = 2;
   localparam int STAT_LINE_LSB = 16;

   // Position ranges, in steps of the position unit
   localparam int LOGO_MIN = -1000;
   localparam int LOGO_MAX = 0;
   localparam int LOGO_DEN = 1000;
   localparam int TEXT_MIN = 0;
   localparam int TEXT_MAX = 100;
   localparam int PCT_DEN = 100;
   localparam int CIRC_MIN = -50;
   localparam int CIRC_MAX = 50;
   localparam int DIAM_MAX = 100;

   // Text store and glyph cell
   localparam int TEXT_LEN = 30;
   localparam int CELL_SH = 4;
   localparam int CELL_H = 24;
   localparam int GLYPH_X0 = 2;
   localparam int GLYPH_X1 = 13;
   localparam int GLYPH_Y0 = 2;
   localparam int GLYPH_Y1 = 21;
   localparam logic [7:0] CHAR_BLANK = 8'h20;
   localparam logic [7:0] CHAR_NUL = 8'h00;

   // Logo bitmap, square, one register per row
   localparam int LOGO_SH = 4;
   localparam int LOGO_N = 16;

   // Overlay colour: Y, Cb, Cr of 10 bits each
   localparam logic [29:0] OVL_PIX = {10'h3AC, 10'h200, 10'h200};

   // Blink timing
   localparam int CLK_KHZ = 125000;
   localparam int FAST_MS = 500;
   localparam int SLOW_MS = 1000;
   localparam int FAST_TOGGLE_CYC = CLK_KHZ * FAST_MS / 2;
   localparam int SLOW_TOGGLE_CYC = CLK_KHZ * SLOW_MS / 2;

   typedef enum logic [1:0] {
      BLINK_OFF,
      BLINK_FAST,
      BLINK_SLOW
   } vom_blink_t;

   typedef enum logic [1:0] {
      OBJ_LOGO,
      OBJ_TEXT,
      OBJ_CIRCLE
   } vom_obj_t;

   typedef struct packed {
      logic sof;
      logic eol;
      logic [29:0] data;
   } vom_pix_t;

   typedef struct packed {
      logic [3:0] logoSel;
      logic textEn;
      logic circEn;
      vom_obj_t obj;
      vom_blink_t blink;
      logic signed [10:0] logoX;
      logic signed [10:0] logoY;
      logic [6:0] textX;
      logic [6:0] textY;
      logic signed [6:0] circX;
      logic signed [6:0] circY;
      logic [6:0] circD;
   } vom_cfg_t;

   typedef struct packed {
      logic signed [13:0] logoX0;
      logic signed [13:0] logoY0;
      logic signed [13:0] textX0;
      logic signed [13:0] textY0;
      logic signed [13:0] circCx;
      logic signed [13:0] circCy;
      logic signed [13:0] circR;
   } vom_geom_t;

endpackage : vom_pkg

//--- hdl/vom_skid.sv
// Two-entry pixel buffer between the mixer and the video output
`timescale 1ns/1ps

module vom_skid #(
   parameter int W = 32
) (
   input wire logic clk,
   input wire logic rstn,
   input wire logic inValid,
   output logic inReady,
   input wire logic [W-1:0] inData,
   output logic outValid,
   input wire logic outReady,
   output logic [W-1:0] outData
);

   typedef struct packed {
      logic valid;
      logic room;
      logic two;
      logic [W-1:0] e0;
      logic [W-1:0] e1;
   } vom_skid_st_t;

   vom_skid_st_t st_r;
   vom_skid_st_t st_nxt;
   logic push;
   logic pop;

   // Flags are kept as flops so both ready and valid leave straight from them
   assign push = inValid & st_r.room;
   assign pop = st_r.valid & outReady;
   assign inReady = st_r.room;
   assign outValid = st_r.valid;
   assign outData = st_r.e0;

   // Entry shuffle: head is e0, e1 only holds a word while e0 is stalled
   always_comb begin
      st_nxt = st_r;
      if (pop) begin
         st_nxt.e0 = st_r.e1;
      end
      if (push) begin
         if (!st_r.valid || (pop && !st_r.two)) begin
            st_nxt.e0 = inData;
         end else begin
            st_nxt.e1 = inData;
         end
      end
      unique case ({push, pop})
         2'b10: begin
            st_nxt.two = st_r.valid;
            st_nxt.valid = 1'b1;
         end
         2'b01: begin
            st_nxt.valid = st_r.two;
            st_nxt.two = 1'b0;
         end
         2'b11, 2'b00: begin
            st_nxt.two = st_r.two;
         end
      endcase
      st_nxt.room = !st_nxt.two;
   end

   always_ff @(posedge clk or negedge rstn) begin
      if (!rstn) begin
         st_r <= '0;
         st_r.room <= 1'b1;
      end else begin
         st_r <= st_nxt;
      end
   end

endmodule : vom_skid

//--- bench/vom_mixer_checker.sv
// Port-level assertions of the overlay mixer
`timescale 1ns/1ps

module vom_mixer_checker (
   input wire logic clk,
   input wire logic rstn,
   input wire logic [9:0] regAddr,
   input wire logic [31:0] regWdata,
   input wire logic regWrite,
   input wire logic regRead,
   input wire logic [31:0] regRdata,
   input wire logic inValid,
   input wire logic inReady,
   input wire vom_pkg::vom_pix_t inPix,
   input wire logic outValid,
   input wire logic outReady,
   input wire vom_pkg::vom_pix_t outPix
);
   default clocking cb @(posedge clk); endclocking
   default disable iff (!rstn);
   // A word entering an empty buffer
   sequence sEmptyTake;
      inValid && inReady && !outValid;
   endsequence
   // Out-of-range writes, answered by a saturated readback
   sequence sTextWr;
      regWrite && regAddr == vom_pkg::REG_TEXT_POS && regWdata[6:0] > 7'h64;
   endsequence
   sequence sDiamWr;
      regWrite && regAddr == vom_pkg::REG_CIRC && regWdata[30:24] > 7'h64;
   endsequence
   AST_RD_IDLE: assert property (!$past(regRead) |-> regRdata == 32'h0)
      else $error("read data not zero outside a read");
   AST_HOLD: assert property (outValid && !outReady |=>
      outValid && $stable(outPix)) else $error("stalled word changed");
   AST_LATENCY: assert property (sEmptyTake |=> outValid)
      else $error("word not out one cycle after entry");
   AST_SOF: assert property (sEmptyTake |=> outPix.sof == $past(inPix.sof))
      else $error("frame start flag altered");
   AST_EOL: assert property (sEmptyTake |=> outPix.eol == $past(inPix.eol))
      else $error("line end flag altered");
   AST_REFUSE: assert property ($fell(inReady) |->
      $past(outValid) && !$past(outReady)) else $error("refused while free");
   AST_TEXT_SAT: assert property ((sTextWr ##1 (regRead &&
      regAddr == vom_pkg::REG_TEXT_POS)) |=> regRdata[6:0] == 7'h64)
      else $error("text position not limited");
   AST_DIAM_SAT: assert property ((sDiamWr ##1 (regRead &&
      regAddr == vom_pkg::REG_CIRC)) |=> regRdata[30:24] == 7'h64)
      else $error("diameter not limited");
endmodule : vom_mixer_checker

bind vom_mixer vom_mixer_checker vom_mixer_checker_i (.clk, .rstn, .regAddr,
   .regWdata, .regWrite, .regRead, .regRdata, .inValid, .inReady, .inPix,
   .outValid, .outReady, .outPix);

//--- bench/vom_video_model.sv
// Pattern source and stalling sink on both sides of the mixer
`timescale 1ns/1ps

module vom_video_model #(
   parameter int W = 32,
   parameter int H = 24
) (
   input wire logic clk,
   input wire logic rstn,
   input wire logic start,
   output logic inValid,
   input wire logic inReady,
   output vom_pkg::vom_pix_t inPix,
   output logic outReady
);
   int n;
   logic [2:0] cyc;
   logic [29:0] pat;
   // Each word carries its own raster position
   assign pat = {10'(n % W), 10'(n / W), 10'h155};
   // Idle lines show the inverse, so a stale word never passes for fresh
   assign inPix = inValid ? {n == 0, n % W == W - 1, pat} : {2'b00, ~pat};
   // Source holds a word until taken; sink stalls 3 cycles in 8
   always @(posedge clk or negedge rstn) begin
      if (!rstn) begin
         n <= 0;
         inValid <= 1'b0;
         cyc <= 3'h0;
         outReady <= 1'b1;
      end else begin
         cyc <= cyc + 3'h1;
         outReady <= cyc < 3'h5;
         if (start) begin
            n <= 0;
            inValid <= 1'b1;
         end else if (inValid && inReady) begin
            n <= n + 1;
            if (n == W * H - 1) inValid <= 1'b0;
         end
      end
   end
endmodule : vom_video_model

//--- bench/tb_top.sv
// Self-checking bench of the overlay mixer
`timescale 1ns/1ps

module tb_top;
   localparam int W = 32;
   localparam int H = 24;
   logic clk, rstn, regWrite, regRead, inValid, inReady, outValid;
   logic outReady, start, blinkOk;
   logic [9:0] regAddr;
   logic [31:0] regWdata, regRdata;
   vom_pkg::vom_pix_t inPix, outPix;
   logic [15:0] logoRow [16];
   int failures, comparisons, frames, hits, mode, px, py;

   vom_mixer #(.ACT_W(W), .ACT_H(H), .FAST_TOGGLE(1000), .SLOW_TOGGLE(2000))
      vom_mixer_i (.clk, .rstn, .regAddr, .regWdata, .regWrite, .regRead,
      .regRdata, .inValid, .inReady, .inPix, .outValid, .outReady, .outPix);
   vom_video_model #(.W(W), .H(H)) vom_video_model_i (.clk, .rstn, .start,
      .inValid, .inReady, .inPix, .outReady);

   initial begin
      clk = 1'b0;
      forever #4 clk = ~clk;
   end

   task automatic chk(input logic [31:0] got, input logic [31:0] exp);
      comparisons++;
      if (got !== exp) begin
         failures++;
         $display("wrong value at %0t: got %h expected %h", $time, got, exp);
      end
   endtask : chk

   // Write, then read back at once: no gap between the strobes
   task automatic wrrd(input logic [9:0] a, input logic [31:0] d,
                       input logic [31:0] e);
      @(posedge clk);
      regAddr <= a;
      regWdata <= d;
      regWrite <= 1'b1;
      @(posedge clk);
      regWrite <= 1'b0;
      regRead <= 1'b1;
      @(posedge clk);
      regRead <= 1'b0;
      #1 chk(regRdata, e);
   endtask : wrrd

   // Expected overlay pixel for each drawing mode
   function automatic logic ovl(int m, int x, int y);
      int r2;
      r2 = (x - 16) * (x - 16) + (y - 12) * (y - 12);
      case (m)
         1: return x >= 8 && x < 24 && y < 16 && logoRow[y][x - 8];
         2: return x >= 2 && x <= 13 && y >= 2 && y <= 21;
         3: return r2 > 25 && r2 <= 36;
         default: return 1'b0;
      endcase
   endfunction : ovl

   // One whole frame through the mixer, judged by the watcher
   task automatic frame(input int m);
      int f;
      f = frames;
      mode = m;
      hits = 0;
      @(posedge clk);
      start <= 1'b1;
      @(posedge clk);
      start <= 1'b0;
      repeat (3000) if (frames == f) @(posedge clk);
      chk(32'(frames), 32'(f + 1));
   endtask : frame

   // Watcher: every accepted word against the expected raster
   always @(posedge clk) begin
      logic [29:0] s;
      logic [29:0] e;
      if (rstn && outValid === 1'b1 && outReady) begin
         s = {10'(px), 10'(py), 10'h155};
         e = ovl(mode, px, py) ? vom_pkg::OVL_PIX : s;
         if (e != s && outPix.data === e) hits++;
         if (blinkOk && outPix.data === s) e = s;
         chk(outPix, {px == 0 && py == 0, px == W - 1, e});
         px = (px == W - 1) ? 0 : px + 1;
         if (px == 0) py = (py == H - 1) ? 0 : py + 1;
         if (px == 0 && py == 0) frames++;
      end
   end

   task automatic t_regs;
      wrrd(vom_pkg::REG_LOGO_POS, 32'h0005_0005, 32'h0);
      wrrd(vom_pkg::REG_LOGO_POS, 32'h0400_0418, 32'h0418_0418);
      wrrd(vom_pkg::REG_TEXT_POS, 32'h0064_0078, 32'h0064_0064);
      wrrd(vom_pkg::REG_CIRC, 32'h7F4D_0033, 32'h644E_0032);
      wrrd(vom_pkg::REG_CTRL, 32'h2231, 32'h2231);
      wrrd(vom_pkg::REG_CTRL, 32'h3300, 32'h2200);
      wrrd(10'h3FC, 32'hFFFF_FFFF, 32'h0);
      wrrd(vom_pkg::REG_CTRL, 32'h0, 32'h0);
      // Status is read-only; before any frame it shows steady visibility
      wrrd(vom_pkg::REG_STATUS, 32'hFFFF_FFFF, 32'h0000_0003);
   endtask : t_regs

   task automatic t_circle;
      wrrd(vom_pkg::REG_CIRC, 32'h3200_0000, 32'h3200_0000);
      wrrd(vom_pkg::REG_CTRL, 32'h0220, 32'h0220);
      frame(0);
      frame(3);
   endtask : t_circle

   task automatic t_text;
      // After a whole frame: running, line count past the last line
      wrrd(vom_pkg::REG_STATUS, 32'h0, 32'h0018_0007);
      wrrd(vom_pkg::REG_TEXT_POS, 32'h0, 32'h0);
      wrrd(vom_pkg::REG_TEXT_BASE, 32'h41, 32'h41);
      wrrd(vom_pkg::REG_TEXT_BASE + 10'h004, 32'h20, 32'h20);
      wrrd(vom_pkg::REG_CTRL, 32'h0110, 32'h0110);
      frame(3);
      frame(2);
   endtask : t_text

   task automatic t_logo;
      wrrd(vom_pkg::REG_LOGO_POS, 32'h0706, 32'h0706);
      wrrd(vom_pkg::REG_LOGO_BASE, 32'h8001, 32'h8001);
      wrrd(vom_pkg::REG_LOGO_BASE + 10'h00C, 32'h00F0, 32'h00F0);
      wrrd(vom_pkg::REG_CTRL, 32'h0001, 32'h0001);
      frame(2);
      frame(1);
      wrrd(vom_pkg::REG_CTRL, 32'h0, 32'h0);
      frame(1);
      frame(0);
   endtask : t_logo

   // Blinking logo: over six frames it must both show and vanish
   task automatic t_blink(input logic [31:0] c);
      int on;
      on = 0;
      wrrd(vom_pkg::REG_CTRL, c, c);
      blinkOk = 1'b1;
      frame(1);
      repeat (6) begin
         frame(1);
         on += int'(hits > 0);
      end
      blinkOk = 1'b0;
      chk(32'(on > 0 && on < 6), 32'h1);
   endtask : t_blink

   // Blink on a disabled logo must never show it
   task automatic t_blink_off;
      wrrd(vom_pkg::REG_CTRL, 32'h1000, 32'h1000);
      blinkOk = 1'b1;
      frame(1);
      blinkOk = 1'b0;
      repeat (3) frame(0);
   endtask : t_blink_off

   task automatic conclude;
      if (failures == 0 && comparisons > 0)
         $display("STATUS OK");
      else
         $display("STATUS NOT OK");
      $finish;
   endtask : conclude

   // Reset, then the scenarios in turn
   initial begin
      {rstn, regWrite, regRead, start, blinkOk} = 5'h0;
      regAddr = 10'h0;
      regWdata = 32'h0;
      {failures, comparisons, frames, hits, mode, px, py} = '0;
      foreach (logoRow[i]) logoRow[i] = 16'h0;
      logoRow[0] = 16'h8001;
      logoRow[3] = 16'h00F0;
      repeat (8) @(posedge clk);
      rstn <= 1'b1;
      t_regs();
      frame(0);
      t_circle();
      t_text();
      t_logo();
      t_blink(32'h1001);
      t_blink(32'h2001);
      t_blink_off();
      conclude();
   end

   // Watchdog against a hung handshake
   initial begin
      repeat (80000) @(posedge clk);
      failures++;
      conclude();
   end
endmodule : tb_top
